// File: adc_ctl_pkg.sv
// constants and types of the converter enable and clock divider block
`default_nettype none
package adc_ctl_pkg;

    // ****************************************************************
    // register map: byte address is four times the index
    // ****************************************************************
    localparam int          ADDR_W     = 20;
    localparam logic [15:0] CTL_INDEX  = 16'h5384;
    localparam logic [15:0] DIV_INDEX  = 16'h5386;
    localparam logic [ADDR_W-1:0] CTL_ADDR = {2'b00, CTL_INDEX, 2'b00};
    localparam logic [ADDR_W-1:0] DIV_ADDR = {2'b00, DIV_INDEX, 2'b00};

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int ENABLE_BIT = 0;
    localparam int RUN_BIT    = 1;
    localparam int BUSY_BIT   = 2;
    localparam int CONT_BIT   = 3;
    localparam int HWSEL_BIT  = 4;

    // ****************************************************************
    // divider field
    // ****************************************************************
    localparam int         SEL_W       = 4;
    localparam int         CNT_W       = 15;
    localparam logic [3:0] SEL_RESET   = 4'h0;
    localparam logic [3:0] SEL_RESERVED = 4'hf;
    localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

    typedef struct packed {
        logic hw_select;
        logic continuous;
        logic run;
        logic enable;
    } ctl_t;

    localparam ctl_t CTL_RESET = '{hw_select: 1'b0, continuous: 1'b0,
                                   run: 1'b0, enable: 1'b0};

endpackage
`default_nettype wire

// File: conv_clock_divider.sv
// power-of-two conversion clock divider
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          clock_supply_on,
    input  wire logic [adc_ctl_pkg::SEL_W-1:0] select,
    output var  logic                          conv_clk
);
    logic [adc_ctl_pkg::CNT_W-1:0] count;
    logic [adc_ctl_pkg::CNT_W-1:0] next_count;

    assign next_count = count + 1'b1;

    // ****************************************************************
    // counter and tap
    // ****************************************************************
    // gated supply holds the chain cleared so the clock restarts in phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (!clock_supply_on) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_clk <= 1'b0;
        end else if (!clock_supply_on || select == adc_ctl_pkg::SEL_RESERVED) begin
            conv_clk <= 1'b0;
        end else begin
            conv_clk <= next_count[select];
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_no_clock_gated;
        @(posedge pclk) disable iff (!presetn)
        !clock_supply_on |=> !conv_clk;
    endproperty
    a_no_clock_gated: assert property (p_no_clock_gated)
        else $error("conversion clock runs while supply is off");

    property p_half_rate;
        @(posedge pclk) disable iff (!presetn)
        (clock_supply_on && select == 4'h0)[*3] |-> conv_clk != $past(conv_clk);
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("divide by two does not toggle every cycle");

endmodule
`default_nettype wire

// File: adc_enable_and_clock_divider.sv
// converter enable, run control and conversion clock divider with apb registers
`timescale 1ns/1ps
`default_nettype none
module adc_enable_and_clock_divider (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [adc_ctl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    output var  logic [31:0]                    prdata,
    output var  logic                           pready,
    output var  logic                           pslverr,
    input  wire logic                           clock_supply_on,
    input  wire logic                           hw_trigger,
    input  wire logic                           conversion_done,
    output var  logic                           conversion_run_control,
    output var  logic                           conversion_start,
    output var  logic                           converter_enable,
    output var  logic                           conversion_continuous,
    output var  logic                           conv_clk
);
    adc_ctl_pkg::ctl_t              ctl;
    logic [adc_ctl_pkg::SEL_W-1:0]  conv_clock_divide_select;
    logic                           hit_ctl;
    logic                           hit_div;
    logic                           access;
    logic                           wr_ctl;
    logic                           wr_div;
    logic                           trig_meta;
    logic                           trig_sync;
    logic                           trig_last;
    logic                           hw_edge;
    logic                           set_sw;
    logic                           set_hw;
    logic                           set_run;
    logic                           clr_run;
    logic                           next_run;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign hit_ctl = paddr == adc_ctl_pkg::CTL_ADDR;
    assign hit_div = paddr == adc_ctl_pkg::DIV_ADDR;
    assign access  = psel && penable;
    assign pready  = 1'b1;
    // unmapped addresses answer with an error and change nothing
    assign pslverr = access && !(hit_ctl || hit_div);
    assign wr_ctl  = access && pwrite && hit_ctl;
    assign wr_div  = access && pwrite && hit_div;

    // read data is captured in setup so the access phase sees a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= adc_ctl_pkg::DATA_ZERO;
        end else if (psel && !penable) begin
            prdata <= adc_ctl_pkg::DATA_ZERO;
            if (hit_ctl) begin
                prdata[adc_ctl_pkg::ENABLE_BIT] <= ctl.enable;
                prdata[adc_ctl_pkg::RUN_BIT]    <= ctl.run;
                prdata[adc_ctl_pkg::BUSY_BIT]   <= ctl.run;
                prdata[adc_ctl_pkg::CONT_BIT]   <= ctl.continuous;
                prdata[adc_ctl_pkg::HWSEL_BIT]  <= ctl.hw_select;
            end else if (hit_div) begin
                prdata[adc_ctl_pkg::SEL_W-1:0] <= conv_clock_divide_select;
            end
        end
    end

    // ****************************************************************
    // control settings
    // ****************************************************************
    // settings change at once; software is expected to disable first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl.enable     <= adc_ctl_pkg::CTL_RESET.enable;
            ctl.continuous <= adc_ctl_pkg::CTL_RESET.continuous;
            ctl.hw_select  <= adc_ctl_pkg::CTL_RESET.hw_select;
        end else if (wr_ctl) begin
            ctl.enable     <= pwdata[adc_ctl_pkg::ENABLE_BIT];
            ctl.continuous <= pwdata[adc_ctl_pkg::CONT_BIT];
            ctl.hw_select  <= pwdata[adc_ctl_pkg::HWSEL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_clock_divide_select <= adc_ctl_pkg::SEL_RESET;
        end else if (wr_div) begin
            conv_clock_divide_select <= pwdata[adc_ctl_pkg::SEL_W-1:0];
        end
    end

    // ****************************************************************
    // hardware trigger synchroniser
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_last <= 1'b0;
        end else begin
            trig_meta <= hw_trigger;
            trig_sync <= trig_meta;
            trig_last <= trig_sync;
        end
    end
    assign hw_edge = trig_sync && !trig_last;

    // ****************************************************************
    // run control
    // ****************************************************************
    assign set_sw  = wr_ctl && pwdata[adc_ctl_pkg::RUN_BIT] && ctl.enable;
    assign set_hw  = hw_edge && ctl.hw_select && ctl.enable;
    assign set_run = set_sw || set_hw;
    // enable is not a term here: dropping it never aborts a conversion
    assign clr_run = (wr_ctl && !pwdata[adc_ctl_pkg::RUN_BIT])
                  || (conversion_done && !ctl.continuous);
    // a new start in the same cycle as a stop wins
    assign next_run = set_run ? 1'b1 : (clr_run ? 1'b0 : ctl.run);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl.run          <= adc_ctl_pkg::CTL_RESET.run;
            conversion_start <= 1'b0;
        end else begin
            ctl.run          <= next_run;
            conversion_start <= set_run && !ctl.run;
        end
    end

    assign conversion_run_control = ctl.run;
    assign converter_enable       = ctl.enable;
    assign conversion_continuous  = ctl.continuous;

    conv_clock_divider u_div (
        .pclk            (pclk),
        .presetn         (presetn),
        .clock_supply_on (clock_supply_on),
        .select          (conv_clock_divide_select),
        .conv_clk        (conv_clk)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_start_needs_enable;
        @(posedge pclk) disable iff (!presetn)
        $rose(ctl.run) |-> $past(ctl.enable);
    endproperty
    a_start_needs_enable: assert property (p_start_needs_enable)
        else $error("conversion started while disabled");

    property p_disable_keeps_run;
        @(posedge pclk) disable iff (!presetn)
        (ctl.run && !ctl.enable && !wr_ctl && !conversion_done) |=> ctl.run;
    endproperty
    a_disable_keeps_run: assert property (p_disable_keeps_run)
        else $error("conversion aborted by enable alone");

    property p_stop_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_ctl && !pwdata[adc_ctl_pkg::RUN_BIT] && !set_hw) |=> !ctl.run;
    endproperty
    a_stop_write: assert property (p_stop_write)
        else $error("write of zero did not stop conversion");

    property p_sw_start;
        @(posedge pclk) disable iff (!presetn)
        (wr_ctl && pwdata[adc_ctl_pkg::RUN_BIT] && ctl.enable)
            |=> ctl.run && ($past(ctl.run) || conversion_start);
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start did not set run");

    property p_hw_start;
        @(posedge pclk) disable iff (!presetn)
        (trig_sync && !trig_last && ctl.hw_select && ctl.enable) |=> ctl.run;
    endproperty
    a_hw_start: assert property (p_hw_start)
        else $error("hardware trigger did not set run");

    property p_one_shot_end;
        @(posedge pclk) disable iff (!presetn)
        (conversion_done && !ctl.continuous && !set_run) |=> !ctl.run;
    endproperty
    a_one_shot_end: assert property (p_one_shot_end)
        else $error("one-time conversion did not stop");

    property p_div_write;
        @(posedge pclk) disable iff (!presetn)
        wr_div |=> conv_clock_divide_select == $past(pwdata[adc_ctl_pkg::SEL_W-1:0]);
    endproperty
    a_div_write: assert property (p_div_write)
        else $error("divider select not stored");

    property p_div_reserved;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit_div) |=> prdata[31:4] == 28'h000_0000;
    endproperty
    a_div_reserved: assert property (p_div_reserved)
        else $error("reserved divider bits read nonzero");

    property p_start_pulse;
        @(posedge pclk) disable iff (!presetn)
        conversion_start |-> ctl.run && !$past(ctl.run);
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse without a fresh run");

    property p_disabled_idle;
        @(posedge pclk) disable iff (!presetn)
        (!ctl.enable && !ctl.run) |=> !ctl.run;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle)
        else $error("run set while converter disabled");

    property p_hw_unselected;
        @(posedge pclk) disable iff (!presetn)
        (hw_edge && !ctl.hw_select && !wr_ctl && !ctl.run) |=> !ctl.run;
    endproperty
    a_hw_unselected: assert property (p_hw_unselected)
        else $error("unselected hardware trigger set run");

endmodule
`default_nettype wire

// File: conv_core_model.sv
// conversion core and trigger source model
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       conversion_start,
    input  wire logic       conversion_run_control,
    input  wire logic [7:0] done_delay,
    input  wire logic       fire,
    output var  logic       conversion_done,
    output var  logic       hw_trigger
);
    // ****************************************************************
    // core: done pulse done_delay cycles after each start, if run control stays high until then
    // ****************************************************************
    logic [7:0] left;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left            <= 8'h00;
            conversion_done <= 1'b0;
        end else begin
            conversion_done <= 1'b0;
            if (conversion_start) begin
                left <= done_delay;
            end else if (left != 8'h00 && conversion_run_control) begin
                left <= left - 8'h01;
                // one-cycle pulse, as the core gives it
                if (left == 8'h01) begin
                    conversion_done <= 1'b1;
                end
            end else begin
                left <= 8'h00;
            end
        end
    end
    // trigger pin is registered on pclk, so its edges are aligned to the clock
    always_ff @(posedge pclk) begin
        hw_trigger <= fire;
    end
endmodule
`default_nettype wire

// File: adc_enable_and_clock_divider_tb.sv
// testbench of the converter enable and clock divider block
`timescale 1ns/1ps
`default_nettype none
module adc_enable_and_clock_divider_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply, fire;
    logic hw_trigger, done, run, start, enable, cont, conv_clk;
    logic [adc_ctl_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  dly;
    int          error_cnt, comparisons;
    adc_enable_and_clock_divider dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_supply_on(supply),
        .hw_trigger(hw_trigger), .conversion_done(done), .conversion_run_control(run),
        .conversion_start(start), .converter_enable(enable),
        .conversion_continuous(cont), .conv_clk(conv_clk));
    conv_core_model core_u (.pclk(pclk), .presetn(presetn), .conversion_start(start),
        .conversion_run_control(run), .done_delay(dly), .fire(fire),
        .conversion_done(done), .hw_trigger(hw_trigger));
    // ****************************************************************
    // bus and check tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic xfer(input logic wr, input logic [19:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        check("pslverr", {31'h0, pslverr}, {31'h0, a != adc_ctl_pkg::CTL_ADDR && a != adc_ctl_pkg::DIV_ADDR});
        psel <= 1'b0; penable <= 1'b0;
        #1;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // trigger level changes on the edge, then settles through the synchroniser
    task automatic trig(input logic level);
        @(posedge pclk);
        fire <= level;
        ticks(8);
    endtask
    task automatic period(input string name, input int exp);
        int n, t0;
        logic p;
        p = conv_clk; n = 0; t0 = -1;
        while (n < 300) begin
            @(posedge pclk); #1;
            if (conv_clk === 1'b1 && p === 1'b0) begin
                if (t0 >= 0) break;
                t0 = n;
            end
            p = conv_clk; n++;
        end
        // no full period seen reads as zero
        check(name, (t0 >= 0 && n < 300) ? n - t0 : 0, exp);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_triggers;
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0012);
        trig(1'b1);
        check("run disabled", {31'h0, run}, 32'h0);
        trig(1'b0);
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0001);
        trig(1'b1);
        check("hw unselected", {31'h0, run}, 32'h0);
        trig(1'b0);
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0003);
        check("start pulse", {31'h0, start}, 32'h1);
        xfer(0, adc_ctl_pkg::CTL_ADDR, 32'h0000_0000);
        check("ctl running", rd, 32'h0000_0007);
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0002);
        check("run kept", {31'h0, run}, 32'h1);
        check("enable off", {31'h0, enable}, 32'h0);
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0000);
        check("run stopped", {31'h0, run}, 32'h0);
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0011);
        trig(1'b1);
        check("hw start", {31'h0, run}, 32'h1);
        trig(1'b0);
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0001);
        $display("triggers test done");
    endtask
    task automatic t_modes;
        @(posedge pclk);
        dly <= 8'h06;
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0003); ticks(12);
        check("one-time end", {31'h0, run}, 32'h0);
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_000b); ticks(12);
        check("continuous", {31'h0, run & cont}, 32'h1);
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0009);
        check("cont stop", {31'h0, run}, 32'h0);
        $display("modes test done");
    endtask
    task automatic t_divider;
        xfer(1, adc_ctl_pkg::CTL_ADDR, 32'h0000_0000);
        xfer(0, adc_ctl_pkg::DIV_ADDR, 32'h0000_0000);
        check("div reset", rd, 32'h0000_0000);
        period("div 1/2", 2);
        for (int s = 1; s < 6; s += 2) begin
            xfer(1, adc_ctl_pkg::DIV_ADDR, {28'hffff_fff, s[3:0]});
            xfer(0, adc_ctl_pkg::DIV_ADDR, 32'h0000_0000);
            check("div read", rd, {28'h0, s[3:0]});
            period("div period", 2 << s);
        end
        xfer(1, adc_ctl_pkg::DIV_ADDR, 32'h0000_000f);
        ticks(2);
        period("reserved", 0);
        xfer(1, adc_ctl_pkg::DIV_ADDR, 32'h0000_0000);
        @(posedge pclk);
        supply <= 1'b0;
        ticks(2);
        period("supply off", 0);
        @(posedge pclk);
        supply <= 1'b1;
        xfer(0, 20'h0_0040, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        $display("divider test done");
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ****************************************************************
    // clock, reset, sequence, watchdog
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; supply = 1'b1; fire = 1'b0; dly = 8'h04;
        error_cnt = 0; comparisons = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_triggers;
        t_modes;
        t_divider;
        finish_test;
    end
    initial begin
        #200000;
        error_cnt++;
        finish_test;
    end
endmodule
`default_nettype wire
